// >>> inc/trig_defs.vh
// Purpose: Offsets, field positions, reset values and counts for the trigger comparators
// Assumes: Word-indexed register port, 5-bit address
// Notes: Included by the trig_cmp module only, not by range_match
`ifndef TRIG_DEFS_VH
`define TRIG_DEFS_VH
`define OFS_ADDR1_VAL 5'h00
`define OFS_ADDR1_HI 5'h01
`define OFS_ADDR2_VAL 5'h02
`define OFS_ADDR2_HI 5'h03
`define OFS_DATA1_VAL 5'h04
`define OFS_DATA1_DC 5'h05
`define OFS_DATA2_VAL 5'h06
`define OFS_DATA2_DC 5'h07
`define OFS_STAT1_VAL 5'h08
`define OFS_STAT1_DC 5'h09
`define OFS_STAT2_VAL 5'h0a
`define OFS_STAT2_DC 5'h0b
`define OFS_PROBE_VAL 5'h0c
`define OFS_PROBE_DC 5'h0d
`define OFS_COUNT_LIM 5'h0e
`define OFS_ADDR_MODE 5'h0f
`define OFS_TERM_BASE 5'h10
`define OFS_CONTROL 5'h14
`define OFS_STATUS 5'h15
`define NUM_TERMS 4
`define NUM_CMP 8
`define CTL_RUN 0
`define CTL_TCE 1
`define CTL_WIDE 2
`define CTL_MODE_LO 3
`define CTL_MODE_HI 4
`define AM_RANGE 0
`define AM_OUTER 1
`define CMP_ADDR1 0
`define CMP_ADDR2 1
`define CMP_DATA1 2
`define CMP_DATA2 3
`define CMP_STAT1 4
`define CMP_STAT2 5
`define CMP_PROBE 6
`define CMP_COUNT 7
`define TERM_EN 16
`define TERM_ACT_HALT 17
`define TERM_ACT_COUNT 18
`define RST_WORD 32'h00000000
`define RST_MODE 2'h0
`endif

// >>> rtl/range_match.v
// Purpose: One address comparator, discrete value or range
// Assumes: Operands already selected for the current trace mode
// Notes: Purely combinational
module range_match (
	input wire [31:0] ADDR,
	input wire [31:0] LO,
	input wire [31:0] HI,
	input wire RANGE_EN,
	input wire OUTER,
	output wire HIT
);
	wire in_open;
	wire in_closed;
	// Inner range excludes endpoints, outer includes them
	assign in_open = (ADDR > LO) && (ADDR < HI);
	assign in_closed = (ADDR >= LO) && (ADDR <= HI);
	assign HIT = !RANGE_EN ? (ADDR == LO) : (OUTER ? in_closed : in_open);
endmodule // range_match

// >>> rtl/trig_cmp.v
// Purpose: Bus event trigger comparators with sum-of-products conditions
// Assumes: BUS_END pulses once at the trailing edge of each target bus cycle
// Notes: Shadow registers are copied into the active set on run start or on enable rise while running
`include "trig_defs.vh"

module trig_cmp (
	input wire CORE_CLK,
	input wire RST_N,
	input wire [4:0] REG_ADDR,
	input wire [31:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [31:0] REG_RDATA,
	input wire BUS_END,
	input wire [31:0] BUS_ADDR,
	input wire [31:0] BUS_DATA,
	input wire [15:0] BUS_STATUS,
	input wire [15:0] PROBE_IN,
	output wire HALT_ACTION,
	output reg COUNT_ACTION,
	output reg NULL_CLAUSE,
	output wire MONITOR_ON
);
	// Shadow (software) and active (hardware) sets
	reg [31:0] shadow_r [0:19];
	reg [31:0] active_r [0:19];
	reg [31:0] ctl_r;
	reg [15:0] probe_lat_r;
	reg [15:0] count_r;
	reg tce_d_r;
	reg run_d_r;
	reg halt_seen_r;
	reg [3:0] term_hit_r;
	reg [`NUM_CMP-1:0] cmp_hit;
	reg [3:0] term_hit;
	reg [3:0] null_t;
	reg [`NUM_TERMS-1:0] halt_hit;
	reg [`NUM_TERMS-1:0] cnt_hit;
	wire run;
	wire trace_capture_enable;
	wire wide;
	wire [1:0] mode;
	wire load;
	wire a1_hit;
	wire a2_hit;
	wire [31:0] a1_lo;
	wire [31:0] a2_lo;
	wire [31:0] a1_hi;
	wire [31:0] a2_hi;
	wire [31:0] addr_sel;
	wire [15:0] data_sel;
	wire [15:0] stat_sel;
	integer i;
	integer t;

	assign run = ctl_r[`CTL_RUN];
	assign trace_capture_enable = ctl_r[`CTL_TCE];
	assign wide = ctl_r[`CTL_WIDE];
	assign mode = ctl_r[`CTL_MODE_HI:`CTL_MODE_LO];
	assign MONITOR_ON = run && trace_capture_enable;
	// Reload on run start and on enable rise while running
	assign load = (run && !run_d_r) || (run && trace_capture_enable && !tce_d_r);

	// Masked compare; mask bit set means ignore
	function match16;
		input [15:0] obs;
		input [15:0] val;
		input [15:0] dc;
		begin
			match16 = ((obs ^ val) & ~dc) == 16'h0000;
		end
	endfunction

	// Trace mode routes bus lanes into the comparators
	assign addr_sel = wide ? BUS_ADDR : {8'h00, BUS_ADDR[23:0]};
	assign data_sel = (mode == 2'h1 || wide) ? BUS_DATA[31:16] : BUS_DATA[15:0];
	assign stat_sel = (mode == 2'h3) ? {8'h00, BUS_STATUS[7:0]} : BUS_STATUS;
	assign a1_lo = wide ? active_r[`OFS_ADDR1_VAL] : {8'h00, active_r[`OFS_ADDR1_VAL][23:0]};
	assign a2_lo = wide ? active_r[`OFS_ADDR2_VAL] : {8'h00, active_r[`OFS_ADDR2_VAL][23:0]};
	assign a1_hi = wide ? active_r[`OFS_ADDR1_HI] : {8'h00, active_r[`OFS_ADDR1_HI][23:0]};
	assign a2_hi = wide ? active_r[`OFS_ADDR2_HI] : {8'h00, active_r[`OFS_ADDR2_HI][23:0]};

	range_match u_addr1 (
		.ADDR(addr_sel),
		.LO(a1_lo),
		.HI(a1_hi),
		.RANGE_EN(active_r[`OFS_ADDR_MODE][`AM_RANGE]),
		.OUTER(active_r[`OFS_ADDR_MODE][`AM_OUTER]),
		.HIT(a1_hit)
	);

	range_match u_addr2 (
		.ADDR(addr_sel),
		.LO(a2_lo),
		.HI(a2_hi),
		.RANGE_EN(active_r[`OFS_ADDR_MODE][`AM_RANGE+2]),
		.OUTER(active_r[`OFS_ADDR_MODE][`AM_OUTER+2]),
		.HIT(a2_hit)
	);

	// Comparator hits for the current bus cycle
	always @* begin
		cmp_hit[`CMP_ADDR1] = a1_hit;
		cmp_hit[`CMP_ADDR2] = a2_hit;
		cmp_hit[`CMP_DATA1] = match16(data_sel, active_r[`OFS_DATA1_VAL][15:0],
			active_r[`OFS_DATA1_DC][15:0]);
		cmp_hit[`CMP_DATA2] = match16(data_sel, active_r[`OFS_DATA2_VAL][15:0],
			active_r[`OFS_DATA2_DC][15:0]);
		cmp_hit[`CMP_STAT1] = match16(stat_sel, active_r[`OFS_STAT1_VAL][15:0],
			active_r[`OFS_STAT1_DC][15:0]);
		cmp_hit[`CMP_STAT2] = match16(stat_sel, active_r[`OFS_STAT2_VAL][15:0],
			active_r[`OFS_STAT2_DC][15:0]);
		// Probe holds the low half of a wide data word
		cmp_hit[`CMP_PROBE] = wide ?
			match16(BUS_DATA[15:0], active_r[`OFS_PROBE_VAL][15:0],
			active_r[`OFS_PROBE_DC][15:0]) :
			match16(probe_lat_r, active_r[`OFS_PROBE_VAL][15:0],
			active_r[`OFS_PROBE_DC][15:0]);
		cmp_hit[`CMP_COUNT] = (count_r == 16'h0000);
	end

	// Flat product terms: must-match bits [7:0], must-differ bits [15:8]
	always @* begin
		for (t = 0; t < `NUM_TERMS; t = t + 1) begin
			null_t[t] = active_r[`OFS_TERM_BASE+t][`TERM_EN] &&
				((active_r[`OFS_TERM_BASE+t][7:0] & active_r[`OFS_TERM_BASE+t][15:8])
				!= 8'h00);
			term_hit[t] = active_r[`OFS_TERM_BASE+t][`TERM_EN] && !null_t[t] &&
				((cmp_hit | ~active_r[`OFS_TERM_BASE+t][7:0]) == 8'hff) &&
				((~cmp_hit | ~active_r[`OFS_TERM_BASE+t][15:8]) == 8'hff);
			halt_hit[t] = term_hit[t] && active_r[`OFS_TERM_BASE+t][`TERM_ACT_HALT];
			cnt_hit[t] = term_hit[t] && active_r[`OFS_TERM_BASE+t][`TERM_ACT_COUNT];
		end
	end

	// Terms OR independently onto each action, halt in the bus cycle itself, count one cycle later
	assign HALT_ACTION = MONITOR_ON && BUS_END && (|halt_hit);

	// Register writes and the active copy
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (i = 0; i < 20; i = i + 1) begin
				shadow_r[i] <= `RST_WORD;
			end
			for (i = 0; i < 20; i = i + 1) begin
				active_r[i] <= `RST_WORD;
			end
			ctl_r <= `RST_WORD;
			run_d_r <= 1'b0;
			tce_d_r <= 1'b0;
		end else begin
			run_d_r <= run;
			tce_d_r <= trace_capture_enable;
			if (REG_WR && REG_ADDR == `OFS_CONTROL) begin
				ctl_r <= {27'h0000000, REG_WDATA[4:0]};
			end
			if (REG_WR && REG_ADDR < `OFS_CONTROL) begin
				shadow_r[REG_ADDR] <= REG_WDATA;
			end
			if (load) begin
				for (i = 0; i < 20; i = i + 1) begin
					active_r[i] <= shadow_r[i];
				end
			end
		end
	end

	// Probe latch, counter and flags
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			probe_lat_r <= 16'h0000;
			count_r <= 16'h0000;
			COUNT_ACTION <= 1'b0;
			NULL_CLAUSE <= 1'b0;
			halt_seen_r <= 1'b0;
			term_hit_r <= 4'h0;
		end else begin
			COUNT_ACTION <= 1'b0;
			if (BUS_END) begin
				probe_lat_r <= PROBE_IN;
			end
			if (load) begin
				count_r <= shadow_r[`OFS_COUNT_LIM][15:0];
				NULL_CLAUSE <= 1'b0;
				halt_seen_r <= 1'b0;
			end else if (MONITOR_ON && BUS_END) begin
				term_hit_r <= term_hit;
				if (|cnt_hit) begin
					COUNT_ACTION <= 1'b1;
					if (count_r != 16'h0000) begin
						count_r <= count_r - 16'h0001;
					end
				end
				if (|halt_hit) begin
					halt_seen_r <= 1'b1;
				end
			end
			if (MONITOR_ON && |null_t) begin
				NULL_CLAUSE <= 1'b1;
			end
		end
	end

	// Read port, data in the following cycle
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 32'h00000000;
		end else if (REG_RD) begin
			if (REG_ADDR < `OFS_CONTROL) begin
				REG_RDATA <= shadow_r[REG_ADDR];
			end else if (REG_ADDR == `OFS_CONTROL) begin
				REG_RDATA <= ctl_r;
			end else if (REG_ADDR == `OFS_STATUS) begin
				REG_RDATA <= {24'h000000, term_hit_r, halt_seen_r, NULL_CLAUSE,
					MONITOR_ON, cmp_hit[`CMP_COUNT]};
			end else begin
				REG_RDATA <= 32'h00000000;
			end
		end
	end
endmodule // trig_cmp

// >>> testbench/trig_monitor.sv
// Purpose: Port checker for trig_cmp
// Assumes: One clock, async active-low reset
// Notes: Bound below
module trig_monitor (
	input wire CORE_CLK,
	input wire RST_N,
	input wire [4:0] REG_ADDR,
	input wire [31:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	input wire [31:0] REG_RDATA,
	input wire BUS_END,
	input wire HALT_ACTION,
	input wire COUNT_ACTION,
	input wire MONITOR_ON
);
	timeunit 1ns;
	timeprecision 1ps;
	wire both_on = REG_WDATA[0] & REG_WDATA[1];
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	chk_halt_in_end: assert property (HALT_ACTION |-> BUS_END)
		else $error("halt outside bus end");
	chk_halt_needs_mon: assert property (HALT_ACTION |-> MONITOR_ON)
		else $error("halt while off");
	chk_count_after_end: assert property (COUNT_ACTION |-> $past(BUS_END))
		else $error("count without bus end");
	chk_count_needs_mon: assert property (COUNT_ACTION |-> $past(MONITOR_ON))
		else $error("count while off");
	chk_mon_follows_ctl: assert property (REG_WR && REG_ADDR == 5'h14 |=> MONITOR_ON == $past(both_on))
		else $error("monitor level wrong");
	chk_unmapped_zero: assert property (REG_RD && REG_ADDR > 5'h15 |=> REG_RDATA == 32'h0)
		else $error("unmapped read not zero");
	chk_rdata_holds: assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("read data moved");
	chk_status_mon: assert property (REG_RD && REG_ADDR == 5'h15 |=> REG_RDATA[1] == $past(MONITOR_ON))
		else $error("status monitor bit wrong");
	cover property (HALT_ACTION);
	cover property (COUNT_ACTION);
	cover property ($fell(MONITOR_ON));
endmodule // trig_monitor
bind trig_cmp trig_monitor mon (.CORE_CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
	.REG_RDATA, .BUS_END, .HALT_ACTION, .COUNT_ACTION, .MONITOR_ON);

// >>> testbench/target_bus_model.sv
// Purpose: Target processor bus model
// Assumes: One bus cycle per call
// Notes: Lines show inverse values between cycles
module target_bus_model (
	input wire CORE_CLK,
	input wire HALT_ACTION,
	input wire COUNT_ACTION,
	output logic BUS_END,
	output logic [31:0] BUS_ADDR,
	output logic [31:0] BUS_DATA,
	output logic [15:0] BUS_STATUS,
	output logic [15:0] PROBE_IN
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		BUS_END = 1'b0;
		{BUS_ADDR, BUS_DATA, BUS_STATUS, PROBE_IN} = 96'h0;
	end
	task automatic cycle(input logic [31:0] a, input logic [31:0] d, output logic hit,
		output logic cnt);
		{BUS_ADDR, BUS_DATA, BUS_STATUS, PROBE_IN} <= {a, d, d[31:16], d[15:0]};
		@(posedge CORE_CLK);
		BUS_END <= 1'b1;
		@(negedge CORE_CLK);
		hit = HALT_ACTION;
		@(posedge CORE_CLK);
		BUS_END <= 1'b0;
		{BUS_ADDR, BUS_DATA, BUS_STATUS, PROBE_IN} <= ~{a, d, d[31:16], d[15:0]};
		@(negedge CORE_CLK);
		cnt = COUNT_ACTION;
		@(posedge CORE_CLK);
	endtask
endmodule // target_bus_model

// >>> testbench/trig_cmp_tb.sv
// Purpose: Self-checking bench for trig_cmp
// Assumes: Trace mode 0, narrow and wide
// Notes: Bus cycles come from the partner model
module trig_cmp_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic CORE_CLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, BUS_END, HALT_ACTION, COUNT_ACTION;
	logic NULL_CLAUSE, MONITOR_ON, h, c;
	logic [4:0] REG_ADDR = 0;
	logic [31:0] REG_WDATA = 0, REG_RDATA, BUS_ADDR, BUS_DATA, a, b, d, x;
	logic [15:0] BUS_STATUS, PROBE_IN;
	int failures = 0, compares = 0, cyc = 0;
	trig_cmp dut (.CORE_CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
		.BUS_END, .BUS_ADDR, .BUS_DATA, .BUS_STATUS, .PROBE_IN, .HALT_ACTION, .COUNT_ACTION,
		.NULL_CLAUSE, .MONITOR_ON);
	target_bus_model bus (.CORE_CLK, .HALT_ACTION, .COUNT_ACTION, .BUS_END, .BUS_ADDR, .BUS_DATA,
		.BUS_STATUS, .PROBE_IN);
	initial begin
		forever #2.5 CORE_CLK = ~CORE_CLK;
	end
	always @(posedge CORE_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		if (failures == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t reg got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_hit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t halt got %b exp %b", $time, got, exp);
		end
	endtask
	task automatic cmp_lvl(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t level got %b exp %b", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] ad, input logic [31:0] v);
		{REG_ADDR, REG_WDATA, REG_WR} <= {ad, v, 1'b1};
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
		@(posedge CORE_CLK);
	endtask
	task automatic rd(input logic [4:0] ad, input logic [31:0] m, input logic [31:0] exp);
		{REG_ADDR, REG_RD} <= {ad, 1'b1};
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		@(negedge CORE_CLK);
		cmp_reg(REG_RDATA & m, exp);
		@(posedge CORE_CLK);
	endtask
	task automatic hit(input logic [31:0] ad, input logic [31:0] dv, input logic exp,
		input logic cexp = 1'b0);
		bus.cycle(ad, dv, h, c);
		cmp_hit(h, exp);
		cmp_lvl(c, cexp);
	endtask
	task automatic restart(input logic [31:0] m = 32'h0);
		wr(5'h14, 32'h2 | m);
		wr(5'h14, 32'h3 | m);
		@(posedge CORE_CLK);
	endtask
	function automatic logic want(input logic [31:0] ad, input logic [31:0] dv, input logic [31:0] v);
		return ad[23:0] == v[23:0] && dv[15:0] != 16'h1234;
	endfunction
	initial begin
		void'($urandom(32'h61b6deb6));
		repeat (3) @(posedge CORE_CLK);
		RST_N <= 1'b1;
		@(posedge CORE_CLK);
		a = {9'h001, 23'($urandom)};
		b = {9'h001, 23'($urandom)};
		rd(5'h0e, 32'hffffffff, 32'h0);
		wr(5'h1a, $urandom);
		rd(5'h1a, 32'hffffffff, 32'h0);
		wr(5'h00, a);
		wr(5'h04, 32'h1234);
		wr(5'h10, 32'h0003_0401);
		restart();
		hit(a, 32'h1234, 1'b0);
		hit(a | 32'hff000000, 32'h5555, 1'b1);
		repeat (10) begin
			x = ($urandom & 1) ? a : $urandom;
			d = ($urandom & 1) ? 32'h1234 : $urandom;
			hit(x, d, want(x, d, a));
		end
		wr(5'h00, b);
		hit(a, 32'h0, 1'b1);
		wr(5'h14, 32'h1);
		cmp_lvl(MONITOR_ON, 1'b0);
		hit(a, 32'h0, 1'b0);
		wr(5'h14, 32'h3);
		cmp_lvl(MONITOR_ON, 1'b1);
		hit(b, 32'h0, 1'b1);
		wr(5'h02, 32'd100);
		wr(5'h03, 32'd200);
		wr(5'h0f, 32'h4);
		wr(5'h0e, 32'h4);
		wr(5'h11, 32'h0005_0002);
		wr(5'h12, 32'h0003_0404);
		restart();
		rd(5'h15, 32'h5, 32'h4);
		cmp_lvl(NULL_CLAUSE, 1'b1);
		for (int i = 0; i < 4; i++) hit(32'd100 + i * 33, 32'h1234, 1'b0, i > 0);
		rd(5'h15, 32'h1, 32'h0);
		hit(32'd199, 32'h1234, 1'b0, 1'b1);
		rd(5'h15, 32'h1, 32'h1);
		wr(5'h0f, 32'hc);
		wr(5'h0e, 32'h1);
		restart();
		hit(32'd200, 32'h1234, 1'b0, 1'b1);
		rd(5'h15, 32'h1, 32'h1);
		wr(5'h04, 32'hbeef);
		wr(5'h0c, 32'h1234);
		wr(5'h10, 32'h0003_0044);
		restart(32'h4);
		hit(32'h0, 32'hbeef_1234, 1'b1);
		hit(32'h0, 32'hbeef_1235, 1'b0);
		hit(32'h0, 32'h1234_beef, 1'b0);
		print_verdict();
	end
endmodule // trig_cmp_tb
